/* File: dso_pkg.sv */
// constants for the drive status and monitor output block
package dso_pkg;
	// register byte offsets
	localparam logic [7:0] DSO_OFS_CTRL = 8'h00;
	localparam logic [7:0] DSO_OFS_OL_LEVEL = 8'h04;
	localparam logic [7:0] DSO_OFS_ARRIVAL = 8'h08;
	localparam logic [7:0] DSO_OFS_PID_LEVEL = 8'h0C;
	localparam logic [7:0] DSO_OFS_THM_LEVEL = 8'h10;
	localparam logic [7:0] DSO_OFS_ANALOG_SEL = 8'h14;
	localparam logic [7:0] DSO_OFS_FLAGS = 8'h18;
	localparam logic [7:0] DSO_OFS_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] DSO_OFS_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] DSO_OFS_IRQ_ENABLE = 8'h24;
	// control, analog select and arrival register field positions
	localparam int DSO_POS_OPT0 = 0;
	localparam int DSO_POS_OPT1 = 8;
	localparam int DSO_POS_POL = 16;
	localparam int DSO_POS_OL_MODE = 20;
	localparam int DSO_POS_RUN_SRC = 24;
	localparam int DSO_POS_ANA_FM = 0;
	localparam int DSO_POS_ANA_AM = 8;
	localparam int DSO_POS_ANA_AMI = 16;
	localparam int DSO_POS_DEC_THR = 16;
	// output option codes
	localparam logic [4:0] DSO_OPT_FA1 = 5'h01;
	localparam logic [4:0] DSO_OPT_FA2 = 5'h02;
	localparam logic [4:0] DSO_OPT_OL = 5'h03;
	localparam logic [4:0] DSO_OPT_PID = 5'h04;
	localparam logic [4:0] DSO_OPT_THM = 5'h0D;
	localparam logic [4:0] DSO_OPT_RUN_SRC = 5'h1B;
	localparam logic [2:0] DSO_RUN_SRC_KEYPAD = 3'h2;
	// analog selection codes
	localparam logic [2:0] DSO_ANA_FREQ = 3'h0;
	localparam logic [2:0] DSO_ANA_CURRENT = 3'h1;
	localparam logic [2:0] DSO_ANA_UNUSED = 3'h2;
	localparam logic [2:0] DSO_ANA_DIGITAL = 3'h3;
	localparam logic [2:0] DSO_ANA_VOLTAGE = 3'h4;
	localparam logic [2:0] DSO_ANA_POWER = 3'h5;
	localparam logic [2:0] DSO_ANA_THERMAL = 3'h6;
	localparam logic [2:0] DSO_ANA_RAMP = 3'h7;
	// full scales and limits in 0.1 percent units, thermal limit in 1 percent units
	localparam logic [15:0] DSO_FULL_200 = 16'h07D0;
	localparam logic [15:0] DSO_FULL_100 = 16'h03E8;
	localparam logic [11:0] DSO_OL_MAX = 12'h7D0;
	localparam logic [10:0] DSO_PID_MAX = 11'h3E8;
	localparam logic [7:0] DSO_THM_MAX = 8'h64;
	// values after reset
	localparam logic [10:0] DSO_RST_OL_LEVEL = 11'h3E8;
	localparam logic [15:0] DSO_RST_ARRIVAL = 16'h0000;
	localparam logic [9:0] DSO_RST_PID_LEVEL = 10'h01E;
	localparam logic [6:0] DSO_RST_THM_LEVEL = 7'h50;
	localparam logic DSO_RST_OL_MODE = 1'b1;
	localparam logic [2:0] DSO_RST_RUN_SRC = 3'h1;
	localparam int DSO_NUM_EV = 5;
endpackage

/* File: dso_status_output.sv */
// status flags, terminal outputs and analog monitors of the drive, with an APB register file
// What this block does
// - option 13 drives the thermal warning flag while thermal accumulation exceeds its limit.
// - option 27 flag is on while the run source selector holds keypad code 02.
// - run source flag is off for selector codes 01, 03, 04 and 05.
// - network writes that assign or remove option 27 are refused; reads still answered.
// - analog code 00 shows frequency to maximum, code 01 current to 200 percent.
// - analog code 03, digital frequency, is accepted only on the frequency meter output.
// - codes 04 to 07 show voltage, input power, thermal overload and ramp frequency.
// - overload flag is on while current exceeds the level, settable 0 to 200 percent.
// - the overload flag only warns; it never trips nor limits current.
// - overload mode 00 compares during ramps, 01 at constant speed; default 01.
// - arrival flag rises on the accel threshold and falls on the decel threshold, both 0.
// - option 04 flag is on while the PID error magnitude exceeds the deviation level.
// - deviation level ranges 0.0 to 100 percent in 0.1 percent steps, reset 3.0.
// - thermal warning threshold ranges 0 to 100 percent and resets to 80.
// - each status terminal has a polarity: 00 normally open, 01 inverts the sense.
`timescale 1ns/100ps
module dso_status_output import dso_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic NET_ACCESS,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] OUT_FREQ,
	input wire logic [15:0] MAX_FREQ,
	input wire logic [15:0] RAMP_FREQ,
	input wire logic [11:0] MOTOR_CURRENT,
	input wire logic [11:0] OUT_VOLTAGE,
	input wire logic [11:0] INPUT_POWER,
	input wire logic [11:0] THERMAL_ACCUM,
	input wire logic [11:0] PID_SETPOINT,
	input wire logic [11:0] PID_PROCESS,
	input wire logic ACCELERATING,
	input wire logic DECELERATING,
	output logic THERMAL_WARNING_FLAG,
	output logic RUN_SOURCE_MONITOR_FLAG,
	output logic OVERLOAD_WARNING_FLAG,
	output logic FREQUENCY_ARRIVAL_FLAG,
	output logic PID_DEVIATION_FLAG,
	output logic [1:0] TERM_OUT,
	output logic FREQUENCY_METER_OUTPUT,
	output logic VOLTAGE_METER_OUTPUT,
	output logic CURRENT_METER_OUTPUT,
	output logic IRQ
);
	logic [1:0][4:0] term_opt;
	logic [1:0] term_pol;
	logic ol_mode;
	logic [2:0] run_src;
	logic [10:0] ol_level;
	logic [15:0] acc_thr;
	logic [15:0] dec_thr;
	logic [9:0] pid_level;
	logic [6:0] thm_level;
	logic [2:0][2:0] ana_sel;
	logic [DSO_NUM_EV-1:0] irq_status;
	logic [DSO_NUM_EV-1:0] irq_enable;
	logic [DSO_NUM_EV-1:0] ev;
	logic [DSO_NUM_EV-1:0] clr;
	logic [1:0][4:0] new_opt;
	logic [2:0][2:0] new_ana;
	logic setup;
	logic done;
	logic wr_ok;
	logic net_reject;
	logic next_err;
	logic [31:0] next_rdata;
	logic [11:0] wr_ol;
	logic [10:0] wr_pid;
	logic [7:0] wr_thm;
	logic [11:0] pid_err;
	logic [9:0] pwm_cnt;
	logic [16:0] dig_acc;

	// apb phases and write checks
	assign setup = PSEL & ~PENABLE;
	assign done = PSEL & PENABLE & PREADY;
	assign new_opt[0] = PWDATA[DSO_POS_OPT0+:5];
	assign new_opt[1] = PWDATA[DSO_POS_OPT1+:5];
	assign new_ana[0] = PWDATA[DSO_POS_ANA_FM+:3];
	assign new_ana[1] = PWDATA[DSO_POS_ANA_AM+:3];
	assign new_ana[2] = PWDATA[DSO_POS_ANA_AMI+:3];
	assign wr_ol = (PWDATA[11:0] > DSO_OL_MAX) ? DSO_OL_MAX : PWDATA[11:0];
	assign wr_pid = (PWDATA[10:0] > DSO_PID_MAX) ? DSO_PID_MAX : PWDATA[10:0];
	assign wr_thm = (PWDATA[7:0] > DSO_THM_MAX) ? DSO_THM_MAX : PWDATA[7:0];
	assign net_reject = PWRITE & NET_ACCESS & (PADDR == DSO_OFS_CTRL)
		& (((term_opt[0] == DSO_OPT_RUN_SRC) != (new_opt[0] == DSO_OPT_RUN_SRC))
		| ((term_opt[1] == DSO_OPT_RUN_SRC) != (new_opt[1] == DSO_OPT_RUN_SRC)));
	assign wr_ok = done & PWRITE & ~PSLVERR & CE;

	// read mux and error decode
	always_comb begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		unique case (PADDR)
			DSO_OFS_CTRL: begin
				next_rdata[DSO_POS_OPT0+:5] = term_opt[0];
				next_rdata[DSO_POS_OPT1+:5] = term_opt[1];
				next_rdata[DSO_POS_POL+:2] = term_pol;
				next_rdata[DSO_POS_OL_MODE] = ol_mode;
				next_rdata[DSO_POS_RUN_SRC+:3] = run_src;
				next_err = net_reject;
			end
			DSO_OFS_OL_LEVEL: next_rdata[10:0] = ol_level;
			DSO_OFS_ARRIVAL: next_rdata = {dec_thr, acc_thr};
			DSO_OFS_PID_LEVEL: next_rdata[9:0] = pid_level;
			DSO_OFS_THM_LEVEL: next_rdata[6:0] = thm_level;
			DSO_OFS_ANALOG_SEL: begin
				next_rdata[DSO_POS_ANA_FM+:3] = ana_sel[0];
				next_rdata[DSO_POS_ANA_AM+:3] = ana_sel[1];
				next_rdata[DSO_POS_ANA_AMI+:3] = ana_sel[2];
				// code 03 only on the frequency meter, code 02 undefined anywhere
				next_err = PWRITE & ((new_ana[0] == DSO_ANA_UNUSED)
					| (new_ana[1] == DSO_ANA_UNUSED) | (new_ana[1] == DSO_ANA_DIGITAL)
					| (new_ana[2] == DSO_ANA_UNUSED) | (new_ana[2] == DSO_ANA_DIGITAL));
			end
			DSO_OFS_FLAGS: next_rdata[4:0] = {PID_DEVIATION_FLAG, FREQUENCY_ARRIVAL_FLAG,
				OVERLOAD_WARNING_FLAG, RUN_SOURCE_MONITOR_FLAG, THERMAL_WARNING_FLAG};
			DSO_OFS_IRQ_STATUS: next_rdata[DSO_NUM_EV-1:0] = irq_status;
			DSO_OFS_IRQ_CLEAR: next_rdata = 32'h00000000;
			DSO_OFS_IRQ_ENABLE: next_rdata[DSO_NUM_EV-1:0] = irq_enable;
			default: next_err = 1'b1;
		endcase
	end

	// apb answer one cycle after setup
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else if (CE) begin
			PREADY <= setup & ~PREADY;
			if (setup) begin
				PSLVERR <= next_err;
				PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
			end
		end
	end

	// configuration registers
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			term_opt <= '0;
			term_pol <= 2'h0;
			ol_mode <= DSO_RST_OL_MODE;
			run_src <= DSO_RST_RUN_SRC;
			ol_level <= DSO_RST_OL_LEVEL;
			acc_thr <= DSO_RST_ARRIVAL;
			dec_thr <= DSO_RST_ARRIVAL;
			pid_level <= DSO_RST_PID_LEVEL;
			thm_level <= DSO_RST_THM_LEVEL;
			ana_sel <= '0;
			irq_enable <= '0;
		end else if (wr_ok) begin
			unique case (PADDR)
				DSO_OFS_CTRL: begin
					term_opt <= new_opt;
					term_pol <= PWDATA[DSO_POS_POL+:2];
					ol_mode <= PWDATA[DSO_POS_OL_MODE];
					run_src <= PWDATA[DSO_POS_RUN_SRC+:3];
				end
				DSO_OFS_OL_LEVEL: ol_level <= wr_ol[10:0];
				DSO_OFS_ARRIVAL: begin
					acc_thr <= PWDATA[15:0];
					dec_thr <= PWDATA[DSO_POS_DEC_THR+:16];
				end
				DSO_OFS_PID_LEVEL: pid_level <= wr_pid[9:0];
				DSO_OFS_THM_LEVEL: thm_level <= wr_thm[6:0];
				DSO_OFS_ANALOG_SEL: ana_sel <= new_ana;
				DSO_OFS_IRQ_ENABLE: irq_enable <= PWDATA[DSO_NUM_EV-1:0];
				default: ;
			endcase
		end
	end

	// pid error magnitude
	assign pid_err = (PID_SETPOINT > PID_PROCESS) ? PID_SETPOINT - PID_PROCESS : PID_PROCESS - PID_SETPOINT;

	// status flags, registered once per cycle; overload feeds only flags, terminals and interrupts
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			THERMAL_WARNING_FLAG <= 1'b0;
			RUN_SOURCE_MONITOR_FLAG <= 1'b0;
			OVERLOAD_WARNING_FLAG <= 1'b0;
			FREQUENCY_ARRIVAL_FLAG <= 1'b0;
			PID_DEVIATION_FLAG <= 1'b0;
		end else if (CE) begin
			THERMAL_WARNING_FLAG <= THERMAL_ACCUM > 12'(thm_level) * 12'h00A;
			RUN_SOURCE_MONITOR_FLAG <= run_src == DSO_RUN_SRC_KEYPAD;
			OVERLOAD_WARNING_FLAG <= (MOTOR_CURRENT > 12'(ol_level))
				& (ol_mode ? ~(ACCELERATING | DECELERATING) : (ACCELERATING | DECELERATING));
			if (ACCELERATING & (OUT_FREQ >= acc_thr))
				FREQUENCY_ARRIVAL_FLAG <= 1'b1;
			else if (DECELERATING & (OUT_FREQ < dec_thr))
				FREQUENCY_ARRIVAL_FLAG <= 1'b0;
			PID_DEVIATION_FLAG <= pid_err > 12'(pid_level);
		end
	end

	// terminal function select with polarity
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			TERM_OUT <= 2'h0;
		end else if (CE) begin
			for (int i = 0; i < 2; i++) begin
				unique case (term_opt[i])
					DSO_OPT_FA1, DSO_OPT_FA2: TERM_OUT[i] <= FREQUENCY_ARRIVAL_FLAG ^ term_pol[i];
					DSO_OPT_OL: TERM_OUT[i] <= OVERLOAD_WARNING_FLAG ^ term_pol[i];
					DSO_OPT_PID: TERM_OUT[i] <= PID_DEVIATION_FLAG ^ term_pol[i];
					DSO_OPT_THM: TERM_OUT[i] <= THERMAL_WARNING_FLAG ^ term_pol[i];
					DSO_OPT_RUN_SRC: TERM_OUT[i] <= RUN_SOURCE_MONITOR_FLAG ^ term_pol[i];
					default: TERM_OUT[i] <= term_pol[i];
				endcase
			end
		end
	end

	// interrupt events on rising edges of all flags but run source, and on every error response; set wins over clear
	assign ev = {done & PSLVERR & CE, PID_DEVIATION_FLAG, FREQUENCY_ARRIVAL_FLAG,
		OVERLOAD_WARNING_FLAG, THERMAL_WARNING_FLAG};
	assign clr = (wr_ok && PADDR == DSO_OFS_IRQ_CLEAR) ? PWDATA[DSO_NUM_EV-1:0] : '0;
	logic [DSO_NUM_EV-2:0] flag_d;
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			flag_d <= '0;
			irq_status <= '0;
			IRQ <= 1'b0;
		end else if (CE) begin
			flag_d <= ev[DSO_NUM_EV-2:0];
			irq_status <= (irq_status & ~clr) | {ev[DSO_NUM_EV-1], ev[DSO_NUM_EV-2:0] & ~flag_d};
			IRQ <= |(irq_status & irq_enable);
		end
	end

	// pwm carrier and digital frequency accumulator
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			pwm_cnt <= 10'h000;
			dig_acc <= 17'h00000;
		end else if (CE) begin
			pwm_cnt <= pwm_cnt + 10'h001;
			dig_acc <= dig_acc + {1'b0, OUT_FREQ};
		end
	end

	// three monitor channels: scale selected quantity onto pwm duty
	logic [2:0] mon;
	for (genvar k = 0; k < 3; k++) begin : g_mon
		logic [15:0] val;
		logic [15:0] full;
		always_comb begin
			val = 16'h0000;
			full = DSO_FULL_100;
			unique case (ana_sel[k])
				DSO_ANA_FREQ, DSO_ANA_DIGITAL: begin
					val = OUT_FREQ;
					full = MAX_FREQ;
				end
				DSO_ANA_CURRENT: begin
					val = {4'h0, MOTOR_CURRENT};
					full = DSO_FULL_200;
				end
				DSO_ANA_VOLTAGE: val = {4'h0, OUT_VOLTAGE};
				DSO_ANA_POWER: begin
					val = {4'h0, INPUT_POWER};
					full = DSO_FULL_200;
				end
				DSO_ANA_THERMAL: val = {4'h0, THERMAL_ACCUM};
				DSO_ANA_RAMP: begin
					val = RAMP_FREQ;
					full = MAX_FREQ;
				end
				default: ;
			endcase
		end
		always_ff @(posedge CORE_CLK) begin
			if (!RESET_N)
				mon[k] <= 1'b0;
			else if (CE)
				mon[k] <= (k == 0 && ana_sel[k] == DSO_ANA_DIGITAL) ? dig_acc[16] :
					(26'(pwm_cnt) * 26'(full)) < {val, 10'h000};
		end
	end
	assign FREQUENCY_METER_OUTPUT = mon[0];
	assign VOLTAGE_METER_OUTPUT = mon[1];
	assign CURRENT_METER_OUTPUT = mon[2];

	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	a_thermal_term: assert property (CE && term_opt[0] == DSO_OPT_THM ##1 CE && $stable(term_opt[0])
		|=> TERM_OUT[0] == ($past(THERMAL_WARNING_FLAG) ^ $past(term_pol[0])))
		else $error("thermal terminal wrong");
	a_run_source: assert property (CE
		|=> RUN_SOURCE_MONITOR_FLAG == ($past(run_src) == DSO_RUN_SRC_KEYPAD))
		else $error("run source flag wrong");
	a_net_reject: assert property (done && setup == 1'b0 && PSLVERR && PADDR == DSO_OFS_CTRL
		|=> $stable(term_opt)) else $error("refused write took effect");
	a_fm_only: assert property (ana_sel[1] != DSO_ANA_DIGITAL && ana_sel[2] != DSO_ANA_DIGITAL)
		else $error("digital code outside fm");
	a_ol_range: assert property (ol_level <= 11'h7D0) else $error("overload level out of range");
	a_ol_mode: assert property (CE && ol_mode && (ACCELERATING || DECELERATING)
		|=> !OVERLOAD_WARNING_FLAG) else $error("overload during ramp in mode 01");
	a_arrival: assert property (CE && ACCELERATING && OUT_FREQ >= acc_thr ##1 CE && !DECELERATING
		|=> FREQUENCY_ARRIVAL_FLAG) else $error("arrival flag dropped");
	a_pid_level: assert property (pid_level <= 10'h3E8) else $error("pid level out of range");
	a_thm_level: assert property (thm_level <= 7'h64) else $error("thermal level out of range");
	a_apb_ready: assert property (CE && setup && !PREADY
		|=> PREADY ##1 (!PREADY || !$past(CE))) else $error("apb answer late");
	c_net_reject: cover property (done && PSLVERR && NET_ACCESS);
	c_irq: cover property (!IRQ ##1 IRQ);
	c_arrival: cover property (!FREQUENCY_ARRIVAL_FLAG ##1 FREQUENCY_ARRIVAL_FLAG);
	c_fm_digital: cover property (ana_sel[0] == DSO_ANA_DIGITAL && FREQUENCY_METER_OUTPUT);
endmodule

/* File: testbench.sv */
// self-checking bench for the drive status and monitor output block
`timescale 1ns/100ps
module testbench import dso_pkg::*;;
	logic CORE_CLK, RESET_N, CE, PSEL, PENABLE, PWRITE, NET_ACCESS, ACCELERATING, DECELERATING;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic PREADY, PSLVERR, IRQ, FREQUENCY_METER_OUTPUT, VOLTAGE_METER_OUTPUT, CURRENT_METER_OUTPUT;
	logic [15:0] OUT_FREQ, MAX_FREQ, RAMP_FREQ;
	logic [11:0] MOTOR_CURRENT, OUT_VOLTAGE, INPUT_POWER, THERMAL_ACCUM, PID_SETPOINT, PID_PROCESS;
	logic THERMAL_WARNING_FLAG, RUN_SOURCE_MONITOR_FLAG, OVERLOAD_WARNING_FLAG;
	logic FREQUENCY_ARRIVAL_FLAG, PID_DEVIATION_FLAG;
	logic [1:0] TERM_OUT, pol;
	logic [31:0] seed = 32'h0182;
	logic [31:0] rd;
	logic er, mode, arr, fz;
	logic [2:0] rs;
	logic [4:0] o0, o1;
	int err_total = 0;
	int checked = 0;
	int thm_lv, ol_lv, pid_lv, acc_t, dec_t, n0;
	logic [4:0] opts [7] = '{DSO_OPT_FA1, DSO_OPT_FA2, DSO_OPT_OL, DSO_OPT_PID, DSO_OPT_THM, DSO_OPT_RUN_SRC, 5'h00};
	logic [2:0] codes [6] = '{DSO_ANA_FREQ, DSO_ANA_CURRENT, DSO_ANA_VOLTAGE, DSO_ANA_POWER, DSO_ANA_THERMAL, DSO_ANA_RAMP};
	int duty [6] = '{256, 768, 512, 128, 896, 640};

	dso_status_output i_dso_status_output (.CORE_CLK, .RESET_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.NET_ACCESS, .PRDATA, .PREADY, .PSLVERR, .OUT_FREQ, .MAX_FREQ, .RAMP_FREQ, .MOTOR_CURRENT, .OUT_VOLTAGE,
		.INPUT_POWER, .THERMAL_ACCUM, .PID_SETPOINT, .PID_PROCESS, .ACCELERATING, .DECELERATING,
		.THERMAL_WARNING_FLAG, .RUN_SOURCE_MONITOR_FLAG, .OVERLOAD_WARNING_FLAG, .FREQUENCY_ARRIVAL_FLAG,
		.PID_DEVIATION_FLAG, .TERM_OUT, .FREQUENCY_METER_OUTPUT, .VOLTAGE_METER_OUTPUT, .CURRENT_METER_OUTPUT, .IRQ);

	// free-running core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end

	// xorshift source, fixed start
	function automatic int rnd(input int n);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % n);
	endfunction

	// flag routed to a terminal by its option code
	function automatic logic sel(input logic [4:0] o, input logic [4:0] f);
		case (o)
			DSO_OPT_FA1, DSO_OPT_FA2: return f[3];
			DSO_OPT_OL: return f[2];
			DSO_OPT_PID: return f[4];
			DSO_OPT_THM: return f[0];
			DSO_OPT_RUN_SRC: return f[1];
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] cw(input logic [4:0] a, input logic [4:0] b, input logic [1:0] p);
		return {5'h00, rs, 3'h0, mode, 2'h0, p, 3'h0, b, 3'h0, a};
	endfunction

	task automatic close_out;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		err_total++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask

	task automatic cmp1(input logic g, input logic e, input string m);
		checked++;
		if (g !== e) fail(m);
	endtask

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) fail(m);
	endtask

	// one apb transfer, request held until pready is seen at an edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic n, input logic e);
		int k;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		NET_ACCESS <= n;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge CORE_CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 50);
		if (PREADY !== 1'b1) begin
			fail("no apb answer");
			close_out;
		end else begin
			rd = PRDATA;
			er = PSLVERR;
			cmp1(er, e, "apb error response");
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
			@(posedge CORE_CLK);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic n, input string m);
		acc(1'b0, a, 32'h0, n, 1'b0);
		cmp32(rd, e, m);
	endtask

	task automatic prog;
		ACCELERATING <= 1'b0;
		DECELERATING <= 1'b0;
		acc(1'b1, DSO_OFS_CTRL, cw(o0, o1, pol), 1'b0, 1'b0);
		acc(1'b1, DSO_OFS_OL_LEVEL, 32'(ol_lv), 1'b0, 1'b0);
		acc(1'b1, DSO_OFS_ARRIVAL, {16'(dec_t), 16'(acc_t)}, 1'b0, 1'b0);
		acc(1'b1, DSO_OFS_PID_LEVEL, 32'(pid_lv), 1'b0, 1'b0);
		acc(1'b1, DSO_OFS_THM_LEVEL, 32'(thm_lv), 1'b0, 1'b0);
	endtask

	// expected flags and terminals from the present inputs and settings
	task automatic chk_all;
		logic [4:0] f;
		logic r;
		int d;
		d = int'(PID_SETPOINT) - int'(PID_PROCESS);
		r = ACCELERATING || DECELERATING;
		if (ACCELERATING && int'(OUT_FREQ) >= acc_t) arr = 1'b1;
		else if (DECELERATING && int'(OUT_FREQ) < dec_t) arr = 1'b0;
		f[0] = int'(THERMAL_ACCUM) > thm_lv * 10;
		f[1] = rs == DSO_RUN_SRC_KEYPAD;
		f[2] = int'(MOTOR_CURRENT) > ol_lv && (mode ? !r : r);
		f[3] = arr;
		f[4] = (d < 0 ? -d : d) > pid_lv;
		cmp1(THERMAL_WARNING_FLAG, f[0], "thermal flag");
		cmp1(RUN_SOURCE_MONITOR_FLAG, f[1], "run source flag");
		cmp1(OVERLOAD_WARNING_FLAG, f[2], "overload flag");
		cmp1(FREQUENCY_ARRIVAL_FLAG, f[3], "arrival flag");
		cmp1(PID_DEVIATION_FLAG, f[4], "pid flag");
		cmp32({30'h0, TERM_OUT}, {30'h0, sel(o1, f) ^ pol[1], sel(o0, f) ^ pol[0]}, "terminals");
	endtask

	task automatic step(input int r, input int fq);
		ACCELERATING <= r == 1;
		DECELERATING <= r == 2;
		OUT_FREQ <= 16'(fq);
		repeat (3) @(posedge CORE_CLK);
		chk_all;
	endtask

	// duty of all three meters over one full pwm period
	task automatic meter(input logic [2:0] c, input int e);
		int n [3];
		acc(1'b1, DSO_OFS_ANALOG_SEL, {13'h0, c, 5'h0, c, 5'h0, c}, 1'b0, 1'b0);
		n = '{0, 0, 0};
		repeat (4) @(posedge CORE_CLK);
		repeat (1024) begin
			@(posedge CORE_CLK);
			if (FREQUENCY_METER_OUTPUT === 1'b1) n[0]++;
			if (VOLTAGE_METER_OUTPUT === 1'b1) n[1]++;
			if (CURRENT_METER_OUTPUT === 1'b1) n[2]++;
		end
		foreach (n[k]) cmp1(n[k] >= e - 8 && n[k] <= e + 8, 1'b1, "meter duty");
	endtask

	// main sequence
	initial begin
		{CE, PSEL, PENABLE, PWRITE, NET_ACCESS, ACCELERATING, DECELERATING, RESET_N} = 8'h80;
		{PADDR, PWDATA, OUT_FREQ, RAMP_FREQ} = '0;
		MAX_FREQ = 16'h1000;
		{MOTOR_CURRENT, OUT_VOLTAGE, INPUT_POWER, THERMAL_ACCUM, PID_SETPOINT, PID_PROCESS} = '0;
		{mode, rs, o0, o1, pol, arr} = {1'b1, 3'h1, 10'h000, 2'h0, 1'b0};
		thm_lv = 80;
		ol_lv = 1000;
		pid_lv = 30;
		acc_t = 0;
		dec_t = 0;
		repeat (6) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		@(posedge CORE_CLK);
		rchk(DSO_OFS_CTRL, 32'h0110_0000, 1'b0, "ctrl reset");
		rchk(DSO_OFS_ARRIVAL, 32'h0, 1'b0, "arrival reset");
		rchk(DSO_OFS_PID_LEVEL, 32'h1E, 1'b0, "pid level reset");
		rchk(DSO_OFS_THM_LEVEL, 32'h50, 1'b0, "thermal level reset");
		rchk(DSO_OFS_OL_LEVEL, 32'h3E8, 1'b0, "overload level reset");
		acc(1'b0, 8'h40, 32'h0, 1'b0, 1'b1);
		step(0, 0);
		acc(1'b1, DSO_OFS_PID_LEVEL, 32'h7FF, 1'b0, 1'b0);
		rchk(DSO_OFS_PID_LEVEL, 32'h3E8, 1'b0, "pid level clamp");
		// random settings and inputs, with threshold edges mixed in
		for (int i = 0; i < 300; i++) begin
			if (i % 10 == 0) begin
				o0 = opts[rnd(7)];
				o1 = opts[rnd(7)];
				pol = 2'(rnd(4));
				mode = rnd(2) == 1;
				rs = 3'(1 + rnd(5));
				ol_lv = rnd(2001);
				pid_lv = rnd(1001);
				thm_lv = rnd(101);
				acc_t = rnd(4096);
				dec_t = rnd(4096);
				prog;
			end
			MOTOR_CURRENT <= 12'(i % 4 == 1 ? ol_lv + rnd(2) : rnd(2201));
			THERMAL_ACCUM <= 12'(i % 4 == 0 ? thm_lv * 10 + rnd(2) : rnd(1101));
			PID_SETPOINT <= 12'(rnd(1001));
			PID_PROCESS <= 12'(rnd(1001));
			step(rnd(3), rnd(4096));
		end
		// arrival edges exactly at both thresholds
		acc_t = 1000;
		dec_t = 500;
		prog;
		step(2, 0);
		step(1, 999);
		step(1, 1000);
		step(0, 0);
		step(2, 500);
		step(2, 499);
		// option 27 guarded against network writes
		o0 = DSO_OPT_FA1;
		o1 = DSO_OPT_RUN_SRC;
		prog;
		acc(1'b1, DSO_OFS_CTRL, cw(o0, DSO_OPT_OL, pol), 1'b1, 1'b1);
		acc(1'b1, DSO_OFS_CTRL, cw(DSO_OPT_RUN_SRC, o1, pol), 1'b1, 1'b1);
		acc(1'b1, DSO_OFS_CTRL, cw(o0, o1, ~pol), 1'b1, 1'b0);
		pol = ~pol;
		rchk(DSO_OFS_CTRL, cw(o0, o1, pol), 1'b1, "ctrl network read");
		step(0, 0);
		// reject interrupt raised, cleared and masked
		acc(1'b1, DSO_OFS_IRQ_ENABLE, 32'h10, 1'b0, 1'b0);
		@(posedge CORE_CLK);
		cmp1(IRQ, 1'b1, "irq raised");
		acc(1'b1, DSO_OFS_IRQ_CLEAR, 32'h1F, 1'b0, 1'b0);
		@(posedge CORE_CLK);
		cmp1(IRQ, 1'b0, "irq cleared");
		acc(1'b1, DSO_OFS_IRQ_ENABLE, 32'h0, 1'b0, 1'b0);
		acc(1'b1, DSO_OFS_ANALOG_SEL, 32'h2, 1'b0, 1'b1);
		acc(1'b0, DSO_OFS_IRQ_STATUS, 32'h0, 1'b0, 1'b0);
		cmp1(rd[4], 1'b1, "reject status");
		cmp1(IRQ, 1'b0, "irq masked");
		// digital code only on the frequency meter, then meter duties
		acc(1'b1, DSO_OFS_ANALOG_SEL, 32'h0000_0300, 1'b0, 1'b1);
		acc(1'b1, DSO_OFS_ANALOG_SEL, 32'h0003_0000, 1'b0, 1'b1);
		acc(1'b1, DSO_OFS_ANALOG_SEL, 32'h0000_0003, 1'b0, 1'b0);
		OUT_FREQ <= 16'h0400;
		RAMP_FREQ <= 16'h0A00;
		MOTOR_CURRENT <= 12'h5DC;
		OUT_VOLTAGE <= 12'h1F4;
		INPUT_POWER <= 12'h0FA;
		THERMAL_ACCUM <= 12'h36B;
		// digital output: 0x400 per cycle into a 17-bit accumulator gives 8 rising edges in 1024 cycles
		n0 = 0;
		fz = 1'b1;
		repeat (4) @(posedge CORE_CLK);
		repeat (1024) begin
			@(posedge CORE_CLK);
			if (FREQUENCY_METER_OUTPUT === 1'b1 && fz === 1'b0) n0++;
			fz = FREQUENCY_METER_OUTPUT;
		end
		cmp1(n0 >= 7 && n0 <= 9, 1'b1, "digital frequency rate");
		// clock enable low freezes the flags, then they follow again
		fz = 12'h36B > thm_lv * 10;
		CE <= 1'b0;
		THERMAL_ACCUM <= fz ? 12'h000 : 12'hFFF;
		repeat (3) @(posedge CORE_CLK);
		cmp1(THERMAL_WARNING_FLAG, fz, "flag frozen by clock enable");
		CE <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		cmp1(THERMAL_WARNING_FLAG, !fz, "flag after clock enable");
		THERMAL_ACCUM <= 12'h36B;
		for (int c = 0; c < 6; c++) meter(codes[c], duty[c]);
		close_out;
	end
endmodule
